// File: core/cps_pkg.sv
// package: constants, register map and carriers for the charger power-up sequencer
package cps_pkg;
	// ----------------------------------------
	// clock and time
	// ----------------------------------------
	localparam int unsigned CLK_HZ         = 125000000;
	localparam int unsigned CLK_KHZ        = CLK_HZ / 1000;
	localparam longint unsigned POORSRC_MS     = 30;
	localparam longint unsigned RETRY_S        = 2;
	localparam longint unsigned DGL_MS         = 30;
	localparam longint unsigned TOPOFF_MIN     = 30;
	localparam longint unsigned SAFETY_LONG_HR = 20;
	localparam longint unsigned SAFETY_SHORT_HR = 10;
	localparam longint unsigned SHIP_EXIT_MIN_MS = 900;
	localparam longint unsigned SHIP_EXIT_MAX_MS = 1300;
	localparam longint unsigned FULL_RST_MIN_S  = 8;
	localparam longint unsigned FULL_RST_MAX_S  = 12;
	localparam longint unsigned SW_OFF_MIN_MS   = 250;
	localparam longint unsigned SW_OFF_MAX_MS   = 400;
	localparam longint unsigned SHIP_DLY_MIN_S  = 10;
	localparam longint unsigned SHIP_DLY_MAX_S  = 15;
	localparam longint unsigned WDT_S          = 160;
	localparam longint unsigned BIAS_DLY_MS    = 220;
	localparam longint unsigned DIG_KHZ        = 500;
	localparam longint unsigned LP_KHZ         = 30;
	localparam longint unsigned ALERT_US       = 256;
	// one tick per millisecond of the 125 MHz system clock
	localparam int unsigned MS_CYC    = CLK_KHZ;
	localparam int unsigned MS_W      = 32;
	localparam longint unsigned POORSRC_TICKS  = POORSRC_MS;
	localparam longint unsigned RETRY_TICKS    = RETRY_S * 1000;
	localparam longint unsigned DGL_TICKS      = DGL_MS;
	localparam longint unsigned TOPOFF_TICKS   = TOPOFF_MIN * 60000;
	localparam longint unsigned SAFE_L_TICKS   = SAFETY_LONG_HR * 3600000;
	localparam longint unsigned SAFE_S_TICKS   = SAFETY_SHORT_HR * 3600000;
	localparam longint unsigned SHIP_EXIT_TICKS = (SHIP_EXIT_MIN_MS + SHIP_EXIT_MAX_MS) / 2;
	localparam longint unsigned FULL_RST_TICKS  = (FULL_RST_MIN_S + FULL_RST_MAX_S) * 500;
	localparam longint unsigned SW_OFF_TICKS    = (SW_OFF_MIN_MS + SW_OFF_MAX_MS) / 2;
	localparam longint unsigned SHIP_DLY_TICKS  = (SHIP_DLY_MIN_S + SHIP_DLY_MAX_S) * 500;
	localparam longint unsigned WDT_TICKS      = WDT_S * 1000;
	localparam longint unsigned BIAS_DLY_TICKS = BIAS_DLY_MS;
	localparam int unsigned ALERT_CYC = int'((ALERT_US * CLK_KHZ + 999) / 1000);
	// digital clock dividers: system cycles per half period
	localparam int unsigned DIG_HALF  = int'(CLK_KHZ / (2 * DIG_KHZ));
	localparam int unsigned LP_HALF   = int'(CLK_KHZ / (2 * LP_KHZ));
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_ILIM   = 8'h04;
	localparam logic [7:0] A_VLIM   = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0C;
	localparam logic [7:0] A_WDT    = 8'h10;
	localparam logic [7:0] A_SHIP   = 8'h14;
	// ctrl bit positions
	localparam int unsigned C_HIZ    = 0;
	localparam int unsigned C_HOST   = 1;
	localparam int unsigned C_DET    = 2;
	localparam int unsigned C_TRACK  = 3;
	localparam int unsigned C_SAFE20 = 4;
	localparam int unsigned C_TOPOFF = 5;
	localparam int unsigned C_SWDIS  = 7;
	localparam logic [1:0] TOPOFF_30 = 2'h2;
	// reset values, limit codes and input type codes
	localparam logic [7:0] ILIM_RST  = 8'h04;
	localparam logic [7:0] ILIM_500  = 8'h04;
	localparam logic [7:0] ILIM_2400 = 8'h17;
	localparam logic [7:0] ILIM_200  = 8'h01;
	localparam logic [7:0] VLIM_RST  = 8'h06;
	localparam logic [2:0] TYPE_USB  = 3'h1;
	localparam logic [2:0] TYPE_ADP  = 3'h3;
	localparam logic [2:0] TYPE_NONE = 3'h0;

	typedef enum logic [2:0] {S_IDLE, S_BIAS, S_QUAL, S_WAIT, S_DET, S_VLIM, S_RUN} cps_seq_t;
	typedef enum logic [2:0] {B_ON, B_DLY, B_SHIP, B_RST} cps_bsw_t;

	typedef struct packed {
		logic in_ok;
		logic sleep_ok;
		logic src_ok;
		logic src_sel;
		logic term;
		logic rechg;
		logic ocp;
		logic sys_short;
		logic chg_en;
		logic [7:0] vbat_lim;
	} cps_ana_t;

	typedef struct packed {
		logic       bias_en;
		logic       block_sw;
		logic       qual_load;
		logic       conv_en;
		logic       batt_sw;
		logic       front_good;
		logic [7:0] ilim_eff;
		logic [7:0] vlim_eff;
		logic       chg_done;
		logic       safety_fault;
		logic       wdt_expired;
		logic       lp_clk;
		logic       dig_clk;
	} cps_ctl_t;
endpackage

// File: core/cps_top.sv
// charger power-up sequencer: sequence, timers, button, watchdog and register port
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
// Functional notes
// RL1: load input and qualify source for 30 ms before continuing power-up.
// RL2: on failed qualification retry every 2 seconds until source passes.
// RL3: deglitch termination and recharge conditions for 30 ms.
// RL4: top-off select 10 runs a 30 minute top-off period.
// RL5: safety timer selectable between 20 hours and 10 hours.
// RL6: button low 0.9 to 1.3 s turns battery switch on, leaves ship.
// RL7: button low 8 to 12 s starts full reset cycling battery switch.
// RL8: full reset holds battery switch off 250 to 400 ms.
// RL9: ship request waits 10 to 15 s before switch off.
// RL10: digital clock 500 kHz, 30 kHz low-power clock with bias off.
// RL11: watchdog times out after 160 s unless host services it.
// RL12: power-on reset returns registers to defaults and opens host port.
// RL13: overcurrent opens battery switch, sets disable bit until input returns; a button exit press also closes the switch and clears the bit.
// RL14: attach steps bias, qualification, type detect, voltage limit, converter.
// RL15: bias regulator on only with input good, sleep ok, 220 ms elapsed.
// RL16: high impedance enable turns off blocking switch and bias, battery powers.
// RL17: passing qualification sets input good status and pulses alert.
// RL18: select high gives 500 mA type 001, low gives 2.4 A type 011.
// RL19: detection done drives front-end good, power good, loads limit, alerts.
// RL20: default mode tracks select pin; host mode needs detection enable.
// RL21: voltage limit 4.5 V default; tracking takes greater of limit and battery.
// RL22: soft start clamps input current to lesser of 200 mA and limit.
// RL23: completed charge cycle pulses host alert.
// RL24: each alert is one fixed-length active-low pulse from a counter.
module cps_top #(
	parameter longint unsigned RETRY_T  = cps_pkg::RETRY_TICKS,
	parameter longint unsigned TOPOFF_T = cps_pkg::TOPOFF_TICKS,
	parameter longint unsigned SAFE_L_T = cps_pkg::SAFE_L_TICKS,
	parameter longint unsigned SAFE_S_T = cps_pkg::SAFE_S_TICKS,
	parameter longint unsigned EXIT_T   = cps_pkg::SHIP_EXIT_TICKS,
	parameter longint unsigned FRST_T   = cps_pkg::FULL_RST_TICKS,
	parameter longint unsigned SHIP_T   = cps_pkg::SHIP_DLY_TICKS,
	parameter longint unsigned WDT_T    = cps_pkg::WDT_TICKS,
	parameter int unsigned     MS_C     = cps_pkg::MS_CYC
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	input  wire cps_pkg::cps_ana_t i_ana,
	input  wire logic              i_ship_exit_button_n,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic [7:0]             o_rdata,
	output cps_pkg::cps_ctl_t      o_ctl,
	output logic                   o_alert_n
);
	import cps_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		cps_ana_t   s1;
		cps_ana_t   s2;
		logic       b1;
		logic       b2;
		logic [31:0] pre;
		logic       tick;
		cps_seq_t   seq;
		logic [MS_W-1:0] seq_t;
		cps_bsw_t   bsw;
		logic [MS_W-1:0] bsw_t;
		logic [MS_W-1:0] btn_t;
		logic       btn_exit_done;
		logic [MS_W-1:0] term_t;
		logic [MS_W-1:0] rech_t;
		logic       charging;
		logic       topoff;
		logic [MS_W-1:0] chg_t;
		logic [7:0] ctrl;
		logic [7:0] ilim;
		logic [7:0] vlim;
		logic       in_good;
		logic       pwr_good;
		logic [2:0] in_type;
		logic       safety_fault;
		logic       chg_done;
		logic [MS_W-1:0] wdt_t;
		logic       wdt_exp;
		logic       ship_req;
		logic [7:0] rdata;
		logic [15:0] alert_t;
		logic       alert_q;
		logic [15:0] dig_t;
		logic       dig_clk;
	} cps_st_t;

	cps_st_t st;
	cps_st_t next_st;
	cps_ana_t a;
	logic btn_low;
	logic [7:0] track_v;
	logic [7:0] wsel;

	assign a       = st.s2;
	assign btn_low = ~st.b2;

	always_comb begin
		next_st = st;
		// inputs pass two flops before use
		next_st.s1 = i_ana;
		next_st.s2 = st.s1;
		next_st.b1 = i_ship_exit_button_n;
		next_st.b2 = st.b1;
		// millisecond prescaler for all long timers
		next_st.tick = 1'b0;
		if (st.pre == 32'(MS_C - 1)) begin
			next_st.pre  = 32'h0;
			next_st.tick = 1'b1;
		end else begin
			next_st.pre = st.pre + 32'h1;
		end
		if (st.alert_t != 16'h0) begin
			next_st.alert_t = st.alert_t - 16'h1;
		end
		// alerts queue one deep; launching before the events lets a same-cycle event wait its turn
		if (st.alert_q && st.alert_t == 16'h0) begin
			next_st.alert_t = 16'(ALERT_CYC * 2); // RL24
			next_st.alert_q = 1'b0;
		end

		// ----------------------------------------
		// power-up sequence
		// ----------------------------------------
		if (st.tick) begin
			next_st.seq_t = st.seq_t + 32'h1;
		end
		if (!a.in_ok || st.ctrl[C_HIZ]) begin
			next_st.seq      = S_IDLE; // RL16
			next_st.seq_t    = 32'h0;
			next_st.in_good  = 1'b0;
			next_st.pwr_good = 1'b0;
			next_st.in_type  = TYPE_NONE;
		end else begin
			unique case (st.seq)
				S_IDLE: begin
					next_st.seq   = S_BIAS; // RL14
					next_st.seq_t = 32'h0;
				end
				S_BIAS: begin
					if (!a.sleep_ok) begin
						next_st.seq_t = 32'h0;
					end else if (st.seq_t >= 32'(BIAS_DLY_TICKS)) begin
						next_st.seq   = S_QUAL; // RL15
						next_st.seq_t = 32'h0;
					end
				end
				S_QUAL: begin
					if (st.seq_t >= 32'(POORSRC_TICKS)) begin // RL1
						next_st.seq_t = 32'h0;
						if (a.src_ok) begin
							next_st.seq     = S_DET;
							next_st.in_good = 1'b1; // RL17
							next_st.alert_q = 1'b1;
						end else begin
							next_st.seq = S_WAIT;
						end
					end
				end
				S_WAIT: begin
					if (st.seq_t >= 32'(RETRY_T)) begin
						next_st.seq   = S_QUAL; // RL2
						next_st.seq_t = 32'h0;
					end
				end
				S_DET: begin
					next_st.in_type  = a.src_sel ? TYPE_USB : TYPE_ADP; // RL18
					next_st.ilim     = a.src_sel ? ILIM_500 : ILIM_2400; // RL19
					next_st.pwr_good = 1'b1;
					next_st.alert_q  = 1'b1;
					next_st.seq      = S_VLIM;
				end
				S_VLIM: next_st.seq = S_RUN;
				S_RUN: begin
					// pin tracking in default mode; host mode waits for enable
					if (!st.ctrl[C_HOST] || st.ctrl[C_DET]) begin // RL20
						next_st.ilim    = a.src_sel ? ILIM_500 : ILIM_2400;
						next_st.in_type = a.src_sel ? TYPE_USB : TYPE_ADP;
					end
				end
			endcase
		end

		// ----------------------------------------
		// charge timers and deglitch
		// ----------------------------------------
		if (st.tick) begin
			next_st.term_t = a.term ? st.term_t + 32'h1 : 32'h0;
			next_st.rech_t = a.rechg ? st.rech_t + 32'h1 : 32'h0;
			next_st.chg_t  = st.chg_t + 32'h1;
		end
		if (!st.charging) begin
			if (st.seq == S_RUN && a.chg_en && !st.safety_fault && !st.chg_done) begin
				next_st.charging = 1'b1;
				next_st.chg_t    = 32'h0;
			end
			if (st.chg_done && st.rech_t >= 32'(DGL_TICKS)) begin // RL3
				next_st.chg_done = 1'b0;
			end
		end else if (st.seq != S_RUN || !a.chg_en) begin
			next_st.charging = 1'b0;
			next_st.topoff   = 1'b0;
		end else if (st.topoff) begin
			if (st.chg_t >= 32'(TOPOFF_T)) begin // RL4
				next_st.charging = 1'b0;
				next_st.topoff   = 1'b0;
				next_st.chg_done = 1'b1;
				next_st.alert_q  = 1'b1; // RL23
			end
		end else if (st.term_t >= 32'(DGL_TICKS)) begin // RL3
			if (st.ctrl[C_TOPOFF+1 -: 2] == TOPOFF_30) begin
				next_st.topoff = 1'b1;
				next_st.chg_t  = 32'h0;
			end else begin
				next_st.charging = 1'b0;
				next_st.chg_done = 1'b1;
				next_st.alert_q  = 1'b1; // RL23
			end
		end else if (st.chg_t >= (st.ctrl[C_SAFE20] ? 32'(SAFE_L_T) : 32'(SAFE_S_T))) begin // RL5
			next_st.charging     = 1'b0;
			next_st.safety_fault = 1'b1;
		end
		if (st.seq == S_IDLE) begin
			next_st.chg_done     = 1'b0;
			next_st.safety_fault = 1'b0;
		end

		// ----------------------------------------
		// battery switch and button
		// ----------------------------------------
		if (st.tick) begin
			next_st.bsw_t = st.bsw_t + 32'h1;
			next_st.btn_t = btn_low ? st.btn_t + 32'h1 : 32'h0;
		end
		if (!btn_low) begin
			next_st.btn_exit_done = 1'b0;
		end
		unique case (st.bsw)
			B_ON: begin
				if (a.ocp) begin
					next_st.bsw = B_SHIP;
					next_st.ctrl[C_SWDIS] = 1'b1; // RL13
				end else if (st.ship_req) begin
					next_st.bsw   = B_DLY;
					next_st.bsw_t = 32'h0;
				end else if (st.btn_t >= 32'(FRST_T) && !st.btn_exit_done) begin
					// the exit press must not run on into a full reset
					next_st.bsw   = B_RST; // RL7
					next_st.bsw_t = 32'h0;
				end
			end
			B_DLY: begin
				if (st.bsw_t >= 32'(SHIP_T)) begin
					next_st.bsw = B_SHIP; // RL9
					next_st.ctrl[C_SWDIS] = 1'b1;
				end
			end
			B_SHIP: begin
				if ((btn_low && st.btn_t >= 32'(EXIT_T)) || a.in_ok) begin
					next_st.bsw = B_ON; // RL6
					next_st.btn_exit_done = 1'b1;
					next_st.ctrl[C_SWDIS] = 1'b0; // RL13
				end
			end
			B_RST: begin
				if (st.bsw_t >= 32'(SW_OFF_TICKS)) begin
					next_st.bsw = B_ON; // RL8
				end
			end
		endcase
		// a ship request is spent once the switch leaves the on state
		if (st.bsw != B_ON) begin
			next_st.ship_req = 1'b0;
		end

		// ----------------------------------------
		// watchdog
		// ----------------------------------------
		if (st.tick && !st.wdt_exp) begin
			next_st.wdt_t = st.wdt_t + 32'h1;
		end
		if (st.wdt_t >= 32'(WDT_T) && !st.wdt_exp) begin
			next_st.wdt_exp = 1'b1; // RL11
			next_st.ctrl    = {next_st.ctrl[C_SWDIS], 7'h0};
			next_st.ilim    = ILIM_RST;
			next_st.vlim    = VLIM_RST;
		end

		// ----------------------------------------
		// register port
		// ----------------------------------------
		wsel = i_wdata;
		next_st.rdata = 8'h0;
		if (i_wr) begin
			unique case (i_addr)
				// a hardware set in this cycle outlasts a software clear
				A_CTRL: next_st.ctrl = {next_st.ctrl[C_SWDIS] & (wsel[C_SWDIS] | ~st.ctrl[C_SWDIS]), wsel[6:0]};
				A_ILIM: next_st.ilim = wsel;
				A_VLIM: next_st.vlim = wsel;
				A_WDT: begin
					next_st.wdt_t   = 32'h0;
					next_st.wdt_exp = next_st.wdt_exp & ~st.wdt_exp;
				end
				A_SHIP: next_st.ship_req = wsel[0];
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				A_CTRL:   next_st.rdata = st.ctrl;
				A_ILIM:   next_st.rdata = st.ilim;
				A_VLIM:   next_st.rdata = st.vlim;
				A_STATUS: next_st.rdata = {st.wdt_exp, st.safety_fault, st.chg_done, st.pwr_good,
				                           st.in_good, st.in_type};
				A_WDT:    next_st.rdata = {7'h0, st.wdt_exp};
				A_SHIP:   next_st.rdata = {5'h0, st.bsw};
				default:  next_st.rdata = 8'h0;
			endcase
		end

		// ----------------------------------------
		// digital clock: fast with bias on, slow otherwise
		// ----------------------------------------
		if (st.dig_t >= (o_ctl.bias_en ? 16'(DIG_HALF - 1) : 16'(LP_HALF - 1))) begin // RL10
			next_st.dig_t   = 16'h0;
			next_st.dig_clk = ~st.dig_clk;
		end else begin
			next_st.dig_t = st.dig_t + 16'h1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st      <= '0; // RL12
			st.ilim <= ILIM_RST;
			st.vlim <= VLIM_RST; // RL21
			st.seq  <= S_IDLE;
			st.bsw  <= B_ON;
			st.b1   <= 1'b1;
			st.b2   <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		track_v = a.vbat_lim;
		o_ctl              = '0;
		o_ctl.bias_en      = st.seq != S_IDLE && st.seq != S_BIAS; // RL15 RL16
		o_ctl.block_sw     = o_ctl.bias_en; // RL16
		o_ctl.qual_load    = st.seq == S_QUAL; // RL1
		o_ctl.conv_en      = st.seq == S_RUN; // RL14
		o_ctl.batt_sw      = st.bsw == B_ON || st.bsw == B_DLY;
		o_ctl.front_good   = st.pwr_good; // RL19
		o_ctl.ilim_eff     = (a.sys_short && st.ilim > ILIM_200) ? ILIM_200 : st.ilim; // RL22
		o_ctl.vlim_eff     = (st.ctrl[C_TRACK] && track_v > st.vlim) ? track_v : st.vlim; // RL21
		o_ctl.chg_done     = st.chg_done;
		o_ctl.safety_fault = st.safety_fault;
		o_ctl.wdt_expired  = st.wdt_exp;
		o_ctl.lp_clk       = !o_ctl.bias_en;
		o_ctl.dig_clk      = st.dig_clk;
	end
	assign o_rdata   = st.rdata;
	assign o_alert_n = !(st.alert_t > 16'(ALERT_CYC)); // RL24

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_qual_to_good;
		@(posedge i_clk_sys) disable iff (i_rst)
		$rose(st.in_good) |-> $past(st.seq) == S_QUAL && $past(st.seq_t) >= 32'(POORSRC_TICKS);
	endproperty
	a_qual_to_good: assert property (p_qual_to_good) else $error("input good without qualification"); // RL1
	property p_retry;
		@(posedge i_clk_sys) disable iff (i_rst)
		(st.seq == S_WAIT && next_st.seq == S_QUAL && a.in_ok && !st.ctrl[C_HIZ]) |-> st.seq_t >= 32'(RETRY_T);
	endproperty
	a_retry: assert property (p_retry) else $error("retry left early"); // RL2
	property p_hiz;
		@(posedge i_clk_sys) disable iff (i_rst)
		st.ctrl[C_HIZ] |=> !o_ctl.bias_en && !o_ctl.block_sw;
	endproperty
	a_hiz: assert property (p_hiz) else $error("bias on in high impedance"); // RL16
	property p_type;
		@(posedge i_clk_sys) disable iff (i_rst)
		$past(st.seq) == S_DET && st.seq == S_VLIM |-> st.in_type == ($past(a.src_sel) ? TYPE_USB : TYPE_ADP);
	endproperty
	a_type: assert property (p_type) else $error("wrong input type"); // RL18
	property p_clamp;
		@(posedge i_clk_sys) disable iff (i_rst)
		a.sys_short |-> o_ctl.ilim_eff <= ILIM_200 && o_ctl.ilim_eff <= st.ilim;
	endproperty
	a_clamp: assert property (p_clamp) else $error("soft start clamp broken"); // RL22
	property p_ocp;
		@(posedge i_clk_sys) disable iff (i_rst)
		st.bsw == B_ON && a.ocp |=> !o_ctl.batt_sw && st.ctrl[C_SWDIS];
	endproperty
	a_ocp: assert property (p_ocp) else $error("overcurrent not handled"); // RL13
	property p_rst_off;
		@(posedge i_clk_sys) disable iff (i_rst)
		$fell(o_ctl.batt_sw) && st.bsw == B_RST |=> !o_ctl.batt_sw [*8];
	endproperty
	a_rst_off: assert property (p_rst_off) else $error("reset off time too short"); // RL8
	property p_alert;
		@(posedge i_clk_sys) disable iff (i_rst)
		$fell(o_alert_n) |=> !o_alert_n [*8];
	endproperty
	a_alert: assert property (p_alert) else $error("alert pulse too short"); // RL24
	c_run: cover property (@(posedge i_clk_sys) disable iff (i_rst) st.seq == S_RUN);
	c_wait: cover property (@(posedge i_clk_sys) disable iff (i_rst) st.seq == S_WAIT);
	c_done: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(st.chg_done));
	c_frst: cover property (@(posedge i_clk_sys) disable iff (i_rst) st.bsw == B_RST);
endmodule

// File: bench/cps_adapter_model.sv
// adapter model: comparator levels the sequencer sees from the input source
`timescale 1ns/100ps
module cps_adapter_model (
	input  wire logic         i_clk_sys,
	input  wire logic         i_attach,
	input  wire logic         i_src_good,
	input  wire logic         i_sel,
	input  wire logic         i_sys_short,
	input  wire logic         i_ocp,
	input  wire logic         i_term,
	input  wire logic         i_rechg,
	input  wire logic         i_chg_en,
	input  wire logic [7:0]   i_vbat,
	input  wire logic         i_qual_load,
	output cps_pkg::cps_ana_t o_ana
);
	import cps_pkg::*;
	// ----------------------------------------
	// comparator levels
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		o_ana.in_ok     <= i_attach;
		o_ana.sleep_ok  <= i_attach;
		// a weak source only sags under load, so unloaded it still reads good
		o_ana.src_ok    <= i_attach & (i_src_good | ~i_qual_load);
		o_ana.src_sel   <= i_sel;
		// the bench plays the charge comparators directly
		o_ana.term      <= i_term;
		o_ana.rechg     <= i_rechg;
		o_ana.chg_en    <= i_chg_en;
		o_ana.ocp       <= i_ocp;
		o_ana.sys_short <= i_sys_short;
		o_ana.vbat_lim  <= i_vbat;
	end
endmodule

// File: bench/test_charger_powerup_sequencer.sv
// testbench: power-up sequence, retry, limits, ship mode, watchdog
`timescale 1ns/100ps
module test_charger_powerup_sequencer;
	import cps_pkg::*;
	localparam int MS = 10;
	logic       i_clk_sys = 1'b0;
	logic       i_rst     = 1'b1;
	logic       btn_n     = 1'b1;
	logic [7:0] i_addr    = 8'h00;
	logic [7:0] i_wdata   = 8'h00;
	logic       i_wr      = 1'b0;
	logic       i_rd      = 1'b0;
	logic       attach    = 1'b0;
	logic       src_good  = 1'b1;
	logic       sel       = 1'b1;
	logic       sys_short = 1'b0;
	logic       ocp       = 1'b0;
	logic       term      = 1'b0;
	logic       rechg     = 1'b0;
	logic       chg_en    = 1'b0;
	logic [7:0] vbat      = 8'h09;
	cps_ana_t   ana;
	cps_ctl_t   ctl;
	logic [7:0] o_rdata;
	logic       o_alert_n;
	int         n_errors   = 0;
	int         num_checks = 0;

	always #4 i_clk_sys = ~i_clk_sys;

	cps_adapter_model adp_u (.i_clk_sys(i_clk_sys), .i_attach(attach), .i_src_good(src_good), .i_sel(sel),
		.i_sys_short(sys_short), .i_ocp(ocp), .i_term(term), .i_rechg(rechg), .i_chg_en(chg_en), .i_vbat(vbat),
		.i_qual_load(ctl.qual_load), .o_ana(ana));
	// short timers keep the run small; fixed 30/220/325 ms stay as built
	cps_top #(.RETRY_T(50), .TOPOFF_T(40), .SAFE_L_T(60), .SAFE_S_T(30), .EXIT_T(11), .FRST_T(100),
		.SHIP_T(20), .WDT_T(600), .MS_C(MS)) dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ana(ana),
		.i_ship_exit_button_n(btn_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_ctl(ctl), .o_alert_n(o_alert_n));

	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n * MS) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge i_clk_sys);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd   <= 1'b0;
		#1;
		chk8(what, exp, o_rdata);
	endtask
	task automatic do_reset();
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		i_rst <= 1'b0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		do_reset();
		rd(A_CTRL, 8'h00, "ctrl");
		rd(A_ILIM, ILIM_RST, "ilim");
		rd(A_VLIM, VLIM_RST, "vlim");
		rd(8'h20, 8'h00, "unmapped");
		wr(A_STATUS, 8'hFF);
		rd(A_STATUS, 8'h00, "status");
		chk1("batt_sw", 1'b1, ctl.batt_sw);
		chk1("lp clk", 1'b1, ctl.lp_clk);
		$display("test reset done");
	endtask
	task automatic t_attach(input logic s);
		logic [7:0] il;
		logic       d;
		il = s ? ILIM_500 : ILIM_2400;
		do_reset();
		sel       <= s;
		sys_short <= 1'b1;
		src_good  <= 1'b1;
		attach    <= 1'b1;
		ticks(210);
		chk1("bias early", 1'b0, ctl.bias_en);
		ticks(20);
		chk1("bias", 1'b1, ctl.bias_en);
		chk1("qual load", 1'b1, ctl.qual_load);
		chk1("conv early", 1'b0, ctl.conv_en);
		chk1("alert early", 1'b1, o_alert_n);
		chk1("lp clk off", 1'b0, ctl.lp_clk);
		d = ctl.dig_clk;
		repeat (DIG_HALF) @(posedge i_clk_sys);
		#1;
		chk1("dig clk", ~d, ctl.dig_clk);
		ticks(32);
		chk1("alert", 1'b0, o_alert_n);
		chk1("front good", 1'b1, ctl.front_good);
		chk1("conv", 1'b1, ctl.conv_en);
		rd(A_STATUS, {3'h0, 2'h3, s ? TYPE_USB : TYPE_ADP}, "status");
		rd(A_ILIM, il, "ilim");
		chk8("ilim soft", ILIM_200, ctl.ilim_eff);
		chk8("vlim", VLIM_RST, ctl.vlim_eff);
		sys_short <= 1'b0;
		ticks(1);
		chk8("ilim run", il, ctl.ilim_eff);
		if (s) begin
			sel <= 1'b0;
			ticks(1);
			rd(A_ILIM, ILIM_2400, "ilim follow");
			wr(A_CTRL, 8'h02);
			sel <= 1'b1;
			ticks(1);
			rd(A_ILIM, ILIM_2400, "ilim held");
			wr(A_CTRL, 8'h06);
			ticks(1);
			rd(A_ILIM, ILIM_500, "ilim det");
			wr(A_CTRL, 8'h01);
			ticks(1);
			chk1("hiz bias", 1'b0, ctl.bias_en);
			chk1("hiz block", 1'b0, ctl.block_sw);
			chk1("hiz batt", 1'b1, ctl.batt_sw);
		end else begin
			wr(A_CTRL, 8'h08);
			ticks(1);
			chk8("vlim track", 8'h09, ctl.vlim_eff);
			vbat <= 8'h05;
			ticks(1);
			chk8("vlim floor", VLIM_RST, ctl.vlim_eff);
		end
		attach <= 1'b0;
		$display("test attach %b done", s);
	endtask
	task automatic t_retry();
		do_reset();
		src_good <= 1'b0;
		sel      <= 1'b1;
		attach   <= 1'b1;
		ticks(262);
		chk1("poor front", 1'b0, ctl.front_good);
		chk1("poor load", 1'b0, ctl.qual_load);
		chk1("poor alert", 1'b1, o_alert_n);
		src_good <= 1'b1;
		ticks(28);
		chk1("wait load", 1'b0, ctl.qual_load);
		ticks(22);
		chk1("retry load", 1'b1, ctl.qual_load);
		ticks(40);
		chk1("retry pass", 1'b1, ctl.front_good);
		attach <= 1'b0;
		$display("test retry done");
	endtask
	task automatic t_charge(input logic top);
		do_reset();
		attach <= 1'b1;
		chg_en <= 1'b1;
		term   <= top;
		wr(A_CTRL, top ? 8'h40 : 8'h00);
		ticks(275);
		if (top) begin
			chk1("topoff early", 1'b0, ctl.chg_done);
			ticks(20);
			chk1("topoff done", 1'b1, ctl.chg_done);
			rechg <= 1'b1;
			ticks(25);
			chk1("rechg early", 1'b1, ctl.chg_done);
			ticks(10);
			chk1("rechg", 1'b0, ctl.chg_done);
		end else begin
			chk1("safety early", 1'b0, ctl.safety_fault);
			ticks(20);
			chk1("safety", 1'b1, ctl.safety_fault);
		end
		attach <= 1'b0;
		chg_en <= 1'b0;
		term   <= 1'b0;
		rechg  <= 1'b0;
		$display("test charge %b done", top);
	endtask
	task automatic t_ship();
		do_reset();
		wr(A_SHIP, 8'h01);
		ticks(15);
		chk1("ship wait", 1'b1, ctl.batt_sw);
		ticks(10);
		chk1("ship off", 1'b0, ctl.batt_sw);
		btn_n <= 1'b0;
		ticks(12);
		btn_n <= 1'b1;
		ticks(1);
		chk1("ship exit", 1'b1, ctl.batt_sw);
		btn_n <= 1'b0;
		ticks(95);
		chk1("rst early", 1'b1, ctl.batt_sw);
		ticks(10);
		btn_n <= 1'b1;
		chk1("rst off", 1'b0, ctl.batt_sw);
		ticks(300);
		chk1("rst hold", 1'b0, ctl.batt_sw);
		ticks(40);
		chk1("rst on", 1'b1, ctl.batt_sw);
		ocp <= 1'b1;
		ticks(1);
		ocp <= 1'b0;
		chk1("ocp off", 1'b0, ctl.batt_sw);
		rd(A_CTRL, 8'h80, "ocp bit");
		$display("test ship done");
	endtask
	task automatic t_wdt();
		do_reset();
		ticks(500);
		wr(A_WDT, 8'h01);
		ticks(550);
		chk1("wdt kicked", 1'b0, ctl.wdt_expired);
		ticks(70);
		chk1("wdt expired", 1'b1, ctl.wdt_expired);
		rd(A_WDT, 8'h01, "wdt reg");
		$display("test watchdog done");
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		t_reset();
		t_attach(1'b1);
		t_attach(1'b0);
		t_retry();
		t_charge(1'b0);
		t_charge(1'b1);
		t_ship();
		t_wdt();
		end_of_test();
	end
	// tests take about 31k cycles; a hang is cut at about twice that
	initial begin
		#500000;
		n_errors++;
		end_of_test();
	end
endmodule
